// *** design/cpmw_pkg.sv ***
package cpmw_pkg;

  // AXI4-Lite register map (byte addresses)
  localparam logic [7:0] CPMW_OFS_CTRL   = 8'h00;
  localparam logic [7:0] CPMW_OFS_STATUS = 8'h04;
  localparam logic [7:0] CPMW_OFS_IRQ    = 8'h08;
  localparam logic [7:0] CPMW_OFS_MASK   = 8'h0C;
  localparam logic [7:0] CPMW_OFS_WAKEF  = 8'h10;
  localparam logic [7:0] CPMW_OFS_DTO    = 8'h14;

  // Interrupt status bit positions
  localparam int CPMW_IRQ_WAKE    = 0;
  localparam int CPMW_IRQ_TIMEOUT = 1;
  localparam int CPMW_IRQ_MODE    = 2;
  localparam int CPMW_IRQ_W       = 3;

  // Control bit positions
  localparam int CPMW_CTRL_TO_EN = 0;

  localparam int CPMW_CNT_W = 32;

  // Clock and times
  localparam int CPMW_CLK_PERIOD_PS = 5000;
  localparam int CPMW_WAKE_FILTER_NS = 5000;
  localparam int CPMW_DOM_TIMEOUT_US = 1000;
  // Wake filter is a least time: rounds up
  localparam int CPMW_WAKE_FILTER_CYC =
    (CPMW_WAKE_FILTER_NS * 1000 + CPMW_CLK_PERIOD_PS - 1) / CPMW_CLK_PERIOD_PS;
  // Dominant timeout is a longest time: rounds down
  localparam int CPMW_DOM_TIMEOUT_CYC =
    (CPMW_DOM_TIMEOUT_US * 1000000) / CPMW_CLK_PERIOD_PS;

  localparam logic [31:0] CPMW_RST_CTRL = 32'h0000_0001;
  localparam logic [31:0] CPMW_RST_MASK = 32'h0000_0000;

  localparam logic [1:0] CPMW_RESP_OKAY   = 2'h0;
  localparam logic [1:0] CPMW_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    CPMW_NORMAL,
    CPMW_STANDBY
  } cpmw_mode_t;

endpackage

// *** design/cpmw_sync.sv ***
`timescale 1ns/1ps
// Two-flop synchroniser per bit
module cpmw_sync #(
  parameter int          W         = 1,
  parameter logic [W-1:0] RST_VAL  = '0
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          meta_q[i]   <= RST_VAL[i];
          sync_out[i] <= RST_VAL[i];
        end else begin
          meta_q[i]   <= async_in[i];
          sync_out[i] <= meta_q[i];
        end
      end
    end
  endgenerate

endmodule

// *** design/cpmw_top.sv ***
// Behaviour
// - Low power select low gives normal mode with driver and main receiver on.
// - Low power select high gives standby with driver and receiver off, only the wake monitor on.
// - In normal mode the bus is driven dominant while the transmit bit is low, recessive while high.
// - In normal mode the receive bit is low on a dominant bus and high on a recessive bus.
// - In standby the receive bit is low while a wake-up request is pending and high otherwise.
// - In standby only a dominant period longer than the wake filter time raises a wake-up request.
// - In standby both bus lines get weak pull-downs and the common-mode output is off.
// - In normal mode the common-mode output is on and the bus stays recessive when not driven.
// - With low power select high or open the transmit bit is ignored and the bus is pulled down weakly.
// - A dominant transmit bit held past the dominant timeout disables the driver until it goes recessive; a bit low on entry to normal mode is never timed out.
// - An open low power select reads as high and an open transmit bit reads as recessive.
//
// The address map and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
module cpmw_top
  import cpmw_pkg::*;
#(
  parameter int WAKE_FILTER_CYC = cpmw_pkg::CPMW_WAKE_FILTER_CYC,
  parameter int DOM_TIMEOUT_CYC = cpmw_pkg::CPMW_DOM_TIMEOUT_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        tx_bit,
  input  wire logic        tx_bit_open,
  input  wire logic        low_power_select,
  input  wire logic        low_power_select_open,
  output logic             rx_bit,
  input  wire logic        bus_dominant,
  output logic             bus_drive_dominant,
  output logic             bus_pulldown_en,
  output logic             split_en,
  output logic             main_rx_en,
  output logic             wake_rx_en,
  output logic             irq,
  input  wire logic [7:0]  s_axil_awaddr,
  input  wire logic        s_axil_awvalid,
  output logic             s_axil_awready,
  input  wire logic [31:0] s_axil_wdata,
  input  wire logic [3:0]  s_axil_wstrb,
  input  wire logic        s_axil_wvalid,
  output logic             s_axil_wready,
  output logic [1:0]       s_axil_bresp,
  output logic             s_axil_bvalid,
  input  wire logic        s_axil_bready,
  input  wire logic [7:0]  s_axil_araddr,
  input  wire logic        s_axil_arvalid,
  output logic             s_axil_arready,
  output logic [31:0]      s_axil_rdata,
  output logic [1:0]       s_axil_rresp,
  output logic             s_axil_rvalid,
  input  wire logic        s_axil_rready
);
  import cpmw_pkg::*;

  localparam logic [2:0] SYNC_RST = 3'b011;

  logic [2:0] sync_in;
  logic [2:0] sync_out;
  logic       tx_s;
  logic       lps_s;
  logic       dom_s;

  // Pins come from outside; reset values make the idle state standby and recessive
  assign sync_in = {bus_dominant, tx_bit | tx_bit_open, low_power_select | low_power_select_open};

  cpmw_sync #(
    .W       (3),
    .RST_VAL (SYNC_RST)
  ) u_sync (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .async_in (sync_in),
    .sync_out (sync_out)
  );

  assign lps_s = sync_out[0];
  assign tx_s  = sync_out[1];
  assign dom_s = sync_out[2];

  cpmw_mode_t mode_q;
  logic       tx_prev_q;
  logic       to_active_q;
  logic [CPMW_CNT_W-1:0] dto_cnt_q;
  logic [CPMW_CNT_W-1:0] wake_cnt_q;
  logic       wake_pend_q;
  logic [31:0] ctrl_q;
  logic [CPMW_IRQ_W-1:0] irq_stat_q;
  logic [CPMW_IRQ_W-1:0] irq_mask_q;
  logic [CPMW_CNT_W-1:0] wake_lim_q;
  logic [CPMW_CNT_W-1:0] dto_lim_q;
  logic       wake_evt;
  logic       to_evt;
  logic       mode_evt;

  // Mode follows the select pin directly
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= CPMW_STANDBY;
    end else begin
      mode_q <= lps_s ? CPMW_STANDBY : CPMW_NORMAL;
    end
  end
  assign mode_evt = (mode_q == CPMW_NORMAL) == lps_s;

  // Dominant timeout: started by falling edge, cleared by recessive input
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_prev_q   <= 1'b1;
      dto_cnt_q   <= '0;
      to_active_q <= 1'b0;
    end else begin
      tx_prev_q <= tx_s;
      if (tx_s || mode_q != CPMW_NORMAL) begin
        dto_cnt_q   <= '0;
        to_active_q <= 1'b0;
      end else if (tx_prev_q && !tx_s) begin
        dto_cnt_q <= CPMW_CNT_W'(1);
      end else if (dto_cnt_q != '0 && !to_active_q) begin
        if (ctrl_q[CPMW_CTRL_TO_EN] && dto_cnt_q >= dto_lim_q) begin
          to_active_q <= 1'b1;
        end else begin
          dto_cnt_q <= dto_cnt_q + CPMW_CNT_W'(1);
        end
      end
    end
  end
  assign to_evt = ctrl_q[CPMW_CTRL_TO_EN] && !to_active_q && dto_cnt_q != '0
                  && dto_cnt_q >= dto_lim_q && !tx_s && mode_q == CPMW_NORMAL;

  // Wake filter counts dominant cycles in standby; request sticks until normal mode
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wake_cnt_q  <= '0;
      wake_pend_q <= 1'b0;
    end else if (mode_q != CPMW_STANDBY) begin
      wake_cnt_q  <= '0;
      wake_pend_q <= 1'b0;
    end else if (!dom_s) begin
      wake_cnt_q <= '0;
    end else if (wake_cnt_q >= wake_lim_q) begin
      wake_pend_q <= 1'b1;
    end else begin
      wake_cnt_q <= wake_cnt_q + CPMW_CNT_W'(1);
    end
  end
  // Fires on the first dominant sample beyond the limit, so a pulse of exactly the limit is ignored
  assign wake_evt = mode_q == CPMW_STANDBY && dom_s && wake_cnt_q >= wake_lim_q && !wake_pend_q;

  // Pin outputs from flops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_bit             <= 1'b1;
      bus_drive_dominant <= 1'b0;
      bus_pulldown_en    <= 1'b1;
      split_en           <= 1'b0;
      main_rx_en         <= 1'b0;
      wake_rx_en         <= 1'b1;
    end else if (mode_q == CPMW_NORMAL) begin
      rx_bit             <= !dom_s;
      bus_drive_dominant <= !tx_s && !to_active_q && !to_evt;
      bus_pulldown_en    <= 1'b0;
      split_en           <= 1'b1;
      main_rx_en         <= 1'b1;
      wake_rx_en         <= 1'b0;
    end else begin
      rx_bit             <= !(wake_pend_q || wake_evt);
      bus_drive_dominant <= 1'b0;
      bus_pulldown_en    <= 1'b1;
      split_en           <= 1'b0;
      main_rx_en         <= 1'b0;
      wake_rx_en         <= 1'b1;
    end
  end

  // AXI4-Lite slave: one write and one read at a time
  logic       aw_hold_q;
  logic       w_hold_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic       wr_go;
  logic       wr_hit;
  logic [CPMW_IRQ_W-1:0] w1c;

  assign s_axil_awready = !aw_hold_q && !s_axil_bvalid;
  assign s_axil_wready  = !w_hold_q && !s_axil_bvalid;
  assign wr_go = aw_hold_q && w_hold_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      aw_addr_q     <= '0;
      w_data_q      <= '0;
      w_strb_q      <= '0;
      s_axil_bvalid <= 1'b0;
      s_axil_bresp  <= CPMW_RESP_OKAY;
    end else begin
      if (s_axil_awvalid && s_axil_awready) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axil_awaddr;
      end
      if (s_axil_wvalid && s_axil_wready) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axil_wdata;
        w_strb_q <= s_axil_wstrb;
      end
      if (wr_go) begin
        aw_hold_q     <= 1'b0;
        w_hold_q      <= 1'b0;
        s_axil_bvalid <= 1'b1;
        s_axil_bresp  <= wr_hit ? CPMW_RESP_OKAY : CPMW_RESP_SLVERR;
      end else if (s_axil_bvalid && s_axil_bready) begin
        s_axil_bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    unique case (aw_addr_q)
      CPMW_OFS_CTRL, CPMW_OFS_IRQ, CPMW_OFS_MASK, CPMW_OFS_WAKEF, CPMW_OFS_DTO, CPMW_OFS_STATUS: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q     <= CPMW_RST_CTRL;
      irq_mask_q <= CPMW_RST_MASK[CPMW_IRQ_W-1:0];
      wake_lim_q <= CPMW_CNT_W'(WAKE_FILTER_CYC);
      dto_lim_q  <= CPMW_CNT_W'(DOM_TIMEOUT_CYC);
    end else if (wr_go) begin
      unique case (aw_addr_q)
        CPMW_OFS_CTRL:  ctrl_q     <= merge(ctrl_q, w_data_q, w_strb_q);
        CPMW_OFS_MASK:  irq_mask_q <= w_strb_q[0] ? w_data_q[CPMW_IRQ_W-1:0] : irq_mask_q;
        CPMW_OFS_WAKEF: wake_lim_q <= merge(wake_lim_q, w_data_q, w_strb_q);
        CPMW_OFS_DTO:   dto_lim_q  <= merge(dto_lim_q, w_data_q, w_strb_q);
        default: ;
      endcase
    end
  end

  // Write-one-to-clear; a new event in the same cycle wins
  assign w1c = (wr_go && aw_addr_q == CPMW_OFS_IRQ && w_strb_q[0]) ? w_data_q[CPMW_IRQ_W-1:0] : '0;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~w1c) | {mode_evt, to_evt, wake_evt};
    end
  end
  assign irq = |(irq_stat_q & irq_mask_q);

  assign s_axil_arready = !s_axil_rvalid;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axil_rvalid <= 1'b0;
      s_axil_rdata  <= '0;
      s_axil_rresp  <= CPMW_RESP_OKAY;
    end else if (s_axil_arvalid && s_axil_arready) begin
      s_axil_rvalid <= 1'b1;
      s_axil_rresp  <= CPMW_RESP_OKAY;
      unique case (s_axil_araddr)
        CPMW_OFS_CTRL:   s_axil_rdata <= ctrl_q;
        CPMW_OFS_STATUS: s_axil_rdata <= {26'h0, wake_pend_q, to_active_q, !tx_s, dom_s, lps_s,
                                          mode_q == CPMW_STANDBY};
        CPMW_OFS_IRQ:    s_axil_rdata <= {29'h0, irq_stat_q};
        CPMW_OFS_MASK:   s_axil_rdata <= {29'h0, irq_mask_q};
        CPMW_OFS_WAKEF:  s_axil_rdata <= wake_lim_q;
        CPMW_OFS_DTO:    s_axil_rdata <= dto_lim_q;
        default: begin
          s_axil_rdata <= 32'h0000_0000;
          s_axil_rresp <= CPMW_RESP_SLVERR;
        end
      endcase
    end else if (s_axil_rvalid && s_axil_rready) begin
      s_axil_rvalid <= 1'b0;
    end
  end

  chk_standby_drive: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mode_q == CPMW_STANDBY |=> !bus_drive_dominant && bus_pulldown_en && !split_en)
    else $error("standby outputs wrong");
  chk_normal_split: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mode_q == CPMW_NORMAL |=> split_en && !bus_pulldown_en && main_rx_en)
    else $error("normal outputs wrong");
  chk_rx_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mode_q == CPMW_NORMAL && dom_s |=> !rx_bit)
    else $error("rx does not follow bus");
  chk_tx_drive: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mode_q == CPMW_NORMAL && tx_s |=> !bus_drive_dominant)
    else $error("recessive tx drove bus");
  chk_mode_select: assert property (@(posedge clk_sys) disable iff (!rst_n)
    lps_s |=> mode_q == CPMW_STANDBY)
    else $error("standby not entered");
  chk_wake_short: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mode_q == CPMW_STANDBY && !wake_pend_q && !dom_s |=> !wake_pend_q)
    else $error("wake without dominant");
  chk_wake_rx: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mode_q == CPMW_STANDBY && $past(mode_q) == CPMW_STANDBY && wake_pend_q |=> !rx_bit)
    else $error("pending wake not shown");
  chk_timeout_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
    to_active_q && !tx_s |=> !bus_drive_dominant)
    else $error("driver on after timeout");
  chk_normal_mode: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !lps_s |=> mode_q == CPMW_NORMAL)
    else $error("normal not entered");

  cov_wake: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(wake_pend_q));
  cov_timeout: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(to_active_q));
  cov_irq: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(irq));

endmodule

// *** verification/cpmw_ctl_model.sv ***
`timescale 1ns/1ps
// Local protocol controller plus the rest of the bus as the transceiver sees it
module cpmw_ctl_model (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic tx_req,
  input  wire logic standby_req,
  input  wire logic auto_wake,
  input  wire logic remote_dom,
  input  wire logic rx_bit,
  input  wire logic bus_drive_dominant,
  output logic      tx_bit,
  output logic      low_power_select,
  output logic      bus_dominant
);
  logic wake_seen;
  logic woken_q;
  // Wired bus: any node driving makes it dominant, else it relaxes recessive
  assign bus_dominant = bus_drive_dominant | remote_dom;
  assign wake_seen = auto_wake & low_power_select & ~rx_bit;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_bit           <= 1'b1;
      low_power_select <= 1'b1;
      woken_q          <= 1'b0;
    end else begin
      tx_bit <= tx_req;
      // Once woken, stay in normal mode until the bench drops its request
      if (wake_seen) begin
        woken_q <= 1'b1;
      end else if (!standby_req) begin
        woken_q <= 1'b0;
      end
      low_power_select <= standby_req && !wake_seen && !woken_q;
    end
  end
endmodule

// *** verification/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import cpmw_pkg::*;
  localparam int WF = 8;
  localparam int DT = 20;
  logic        clk_sys, rst_n, tx_req, standby_req, auto_wake, remote_dom;
  logic        tx_bit, tx_bit_open, low_power_select, low_power_select_open, rx_bit, bus_dominant;
  logic        bus_drive_dominant, bus_pulldown_en, split_en, main_rx_en, wake_rx_en, irq;
  logic [7:0]  s_axil_awaddr, s_axil_araddr;
  logic [31:0] s_axil_wdata, s_axil_rdata, rd;
  logic [3:0]  s_axil_wstrb;
  logic [1:0]  s_axil_bresp, s_axil_rresp, rsp;
  logic        s_axil_awvalid, s_axil_awready, s_axil_wvalid, s_axil_wready, s_axil_bvalid, s_axil_bready;
  logic        s_axil_arvalid, s_axil_arready, s_axil_rvalid, s_axil_rready;
  int          bad_count, comparisons;

  cpmw_top #(.WAKE_FILTER_CYC(WF), .DOM_TIMEOUT_CYC(DT)) dut (.clk_sys, .rst_n, .tx_bit, .tx_bit_open,
    .low_power_select, .low_power_select_open, .rx_bit, .bus_dominant, .bus_drive_dominant, .bus_pulldown_en,
    .split_en, .main_rx_en, .wake_rx_en, .irq, .s_axil_awaddr, .s_axil_awvalid, .s_axil_awready, .s_axil_wdata,
    .s_axil_wstrb, .s_axil_wvalid, .s_axil_wready, .s_axil_bresp, .s_axil_bvalid, .s_axil_bready, .s_axil_araddr,
    .s_axil_arvalid, .s_axil_arready, .s_axil_rdata, .s_axil_rresp, .s_axil_rvalid, .s_axil_rready);

  cpmw_ctl_model ctl (.clk_sys, .rst_n, .tx_req, .standby_req, .auto_wake, .remote_dom, .rx_bit,
    .bus_drive_dominant, .tx_bit, .low_power_select, .bus_dominant);

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check1(input string nm, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic check32(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Valid signals are only released once taken; bready and rready stay high throughout
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    s_axil_awaddr <= a;
    s_axil_wdata <= d;
    s_axil_awvalid <= 1'b1;
    s_axil_wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clk_sys);
      if (!aw_done && s_axil_awready) begin
        aw_done = 1'b1;
        s_axil_awvalid <= 1'b0;
      end
      if (!w_done && s_axil_wready) begin
        w_done = 1'b1;
        s_axil_wvalid <= 1'b0;
      end
    end
    do @(posedge clk_sys); while (!s_axil_bvalid);
    r = s_axil_bresp;
  endtask

  task automatic rdw(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axil_araddr <= a;
    s_axil_arvalid <= 1'b1;
    do @(posedge clk_sys); while (!s_axil_arready);
    s_axil_arvalid <= 1'b0;
    do @(posedge clk_sys); while (!s_axil_rvalid);
    d = s_axil_rdata;
    r = s_axil_rresp;
  endtask

  task automatic t_reset;
    check1("pulldown", 1'b1, bus_pulldown_en);
    check1("split", 1'b0, split_en);
    check1("main rx", 1'b0, main_rx_en);
    check1("wake rx", 1'b1, wake_rx_en);
    check1("rx idle", 1'b1, rx_bit);
    check1("drive", 1'b0, bus_drive_dominant);
  endtask

  task automatic t_regs;
    rdw(CPMW_OFS_CTRL, rd, rsp);
    check32("ctrl reset", CPMW_RST_CTRL, rd);
    rdw(CPMW_OFS_MASK, rd, rsp);
    check32("mask reset", CPMW_RST_MASK, rd);
    wr(CPMW_OFS_WAKEF, WF, rsp);
    wr(CPMW_OFS_DTO, DT, rsp);
    rdw(CPMW_OFS_WAKEF, rd, rsp);
    check32("wake filter", 32'(WF), rd);
    wr(8'h40, 32'hFFFF_FFFF, rsp);
    check32("unmapped wr resp", 32'(CPMW_RESP_SLVERR), 32'(rsp));
    rdw(8'h40, rd, rsp);
    check32("unmapped rd resp", 32'(CPMW_RESP_SLVERR), 32'(rsp));
    check32("unmapped rd data", 32'h0, rd);
    wr(CPMW_OFS_MASK, 32'h7, rsp);
  endtask

  task automatic t_normal;
    standby_req <= 1'b0;
    cyc(8);
    check1("main rx", 1'b1, main_rx_en);
    check1("split", 1'b1, split_en);
    check1("pulldown", 1'b0, bus_pulldown_en);
    check1("wake rx", 1'b0, wake_rx_en);
    check1("mode irq", 1'b1, irq);
    wr(CPMW_OFS_IRQ, 32'h7, rsp);
    rdw(CPMW_OFS_IRQ, rd, rsp);
    check32("irq cleared", 32'h0, rd);
    check1("irq low", 1'b0, irq);
    tx_req <= 1'b0;
    cyc(10);
    check1("drive", 1'b1, bus_drive_dominant);
    check1("rx dom", 1'b0, rx_bit);
    tx_req <= 1'b1;
    cyc(10);
    check1("drive", 1'b0, bus_drive_dominant);
    check1("rx rec", 1'b1, rx_bit);
    remote_dom <= 1'b1;
    cyc(8);
    check1("rx remote", 1'b0, rx_bit);
    remote_dom <= 1'b0;
    cyc(8);
  endtask

  task automatic t_timeout;
    tx_req <= 1'b0;
    cyc(DT + 20);
    check1("drive off", 1'b0, bus_drive_dominant);
    check1("split on", 1'b1, split_en);
    rdw(CPMW_OFS_IRQ, rd, rsp);
    check32("irq timeout", 32'h1 << CPMW_IRQ_TIMEOUT, rd);
    check1("irq", 1'b1, irq);
    tx_req <= 1'b1;
    cyc(8);
    tx_req <= 1'b0;
    cyc(8);
    check1("drive again", 1'b1, bus_drive_dominant);
    wr(CPMW_OFS_CTRL, 32'h0, rsp);
    cyc(DT + 10);
    check1("timeout disabled", 1'b1, bus_drive_dominant);
    tx_req <= 1'b1;
    cyc(6);
    wr(CPMW_OFS_CTRL, CPMW_RST_CTRL, rsp);
    wr(CPMW_OFS_IRQ, 32'h2, rsp);
    check1("irq clear", 1'b0, irq);
  endtask

  task automatic t_open;
    tx_bit_open <= 1'b1;
    tx_req <= 1'b0;
    cyc(10);
    check1("open tx", 1'b0, bus_drive_dominant);
    tx_req <= 1'b1;
    tx_bit_open <= 1'b0;
    low_power_select_open <= 1'b1;
    cyc(8);
    check1("open sel", 1'b1, wake_rx_en);
    low_power_select_open <= 1'b0;
    cyc(8);
    check1("back normal", 1'b1, main_rx_en);
  endtask

  task automatic t_standby_wake;
    standby_req <= 1'b1;
    tx_req <= 1'b0;
    cyc(10);
    t_reset;
    tx_req <= 1'b1;
    wr(CPMW_OFS_IRQ, 32'h7, rsp);
    remote_dom <= 1'b1;
    cyc(WF);
    remote_dom <= 1'b0;
    repeat (12) begin
      @(posedge clk_sys);
      check1("short pulse", 1'b1, rx_bit);
    end
    remote_dom <= 1'b1;
    cyc(WF + 1);
    remote_dom <= 1'b0;
    cyc(4);
    check1("wake rx low", 1'b0, rx_bit);
    check1("wake irq", 1'b1, irq);
    rdw(CPMW_OFS_IRQ, rd, rsp);
    check1("wake flag", 1'b1, rd[CPMW_IRQ_WAKE]);
    wr(CPMW_OFS_MASK, 32'h0, rsp);
    check1("masked", 1'b0, irq);
    auto_wake <= 1'b1;
    cyc(10);
    check1("woken", 1'b1, main_rx_en);
    check1("rx normal", 1'b1, rx_bit);
  endtask

  initial begin
    {tx_req, tx_bit_open, low_power_select_open, standby_req, auto_wake, remote_dom} = 6'b100100;
    {s_axil_awvalid, s_axil_wvalid, s_axil_arvalid, s_axil_bready, s_axil_rready} = 5'b00011;
    s_axil_awaddr = 8'h00;
    s_axil_araddr = 8'h00;
    s_axil_wdata = 32'h0;
    s_axil_wstrb = 4'hF;
    bad_count = 0;
    comparisons = 0;
    rst_n = 1'b0;
    cyc(12);
    rst_n <= 1'b1;
    cyc(6);
    t_reset;
    t_regs;
    t_normal;
    t_timeout;
    t_open;
    t_standby_wake;
    finish_test;
  end

  // The sequence needs well under two thousand cycles
  initial begin
    cyc(20000);
    bad_count++;
    finish_test;
  end
endmodule
